//--- core/tsn_config_phase_scheduler.sv
// configuration record, apply groups, gating and simple phase scheduler
`timescale 1ns/1ps
`default_nettype none
module tsn_config_phase_scheduler
  import tsn_sched_pkg::*;
#(
  parameter bit          signal_config_mode = 1'b0,
  parameter int unsigned SUP_TIMEOUT_CYC    = `SUP_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic            core_clk_i,
  input  wire logic            rst_n_i,
  // signal configuration
  input  wire cfg_t            static_cfg_i,
  input  wire apply_t          static_apply_i,
  // register port
  input  wire logic [9:0]      reg_addr_i,
  input  wire logic [31:0]     reg_wdata_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  output logic      [31:0]     reg_rdata_o,
  // frame classification
  input  wire frame_desc_t     frame_i,
  output frame_verdict_t       verdict_o,
  // queue activity for shaping
  input  wire logic [7:0]      queue_pending_i,
  input  wire logic [7:0]      queue_sending_i,
  // supervision frame events
  input  wire logic            side_a_sup_frame_i,
  input  wire logic            side_b_sup_frame_i,
  // configuration and gating
  output cfg_t                 active_cfg_o,
  output logic      [7:0]      queue_active_o,
  output logic      [7:0]      shaper_allow_o,
  output logic      [7:0]      preempt_allow_o,
  output logic                 cyclic_forward_o,
  output logic                 early_forward_o,
  // status
  output status_t              status_o,
  output logic                 phase_valid_o
);
  localparam int NQ = `MAX_QUEUES;
  localparam logic [31:0] PERIOD_NS = 32'(`CLK_PERIOD_NS);
  localparam logic [31:0] SUP_LIMIT = 32'(SUP_TIMEOUT_CYC);

  cfg_t           shadow_q;
  cfg_t           active_q;
  cfg_t           cfg_src;
  apply_t         bus_apply_q;
  apply_t         apply_src;
  status_t        status_q;
  logic [NQ-1:0]  phase_q;
  logic           cycle_start_q;
  logic           core_enabled_q;
  logic [1:0]     lost_flag_q;
  frame_verdict_t verdict_q;
  logic [31:0]    rd_mux;
  logic [31:0]    rdata_q;
  logic [4:0]     blk;
  logic [2:0]     qi;
  logic [31:0]    elapsed_q;
  logic [32:0]    next_el;
  logic           wrap;
  logic           phase_run;
  logic           run_q;
  logic           phase_valid_q;
  logic [1:0][31:0] sup_cnt_q;
  logic [1:0]     sup_evt;
  logic [1:0]     lost_q;
  logic signed [17:0] credit_q [NQ];
  logic [7:0]     queue_active_q;
  logic [7:0]     shaper_allow_q;
  logic [7:0]     preempt_allow_q;
  logic           cyclic_q;
  logic           early_q;
  logic [2:0]     sel_queue;

  assign blk = reg_addr_i[9:5];
  assign qi  = reg_addr_i[4:2];

  // status record gathered from one flop per concern
  assign status_q = {phase_q, cycle_start_q, lost_flag_q, core_enabled_q};

  // configuration source fixed at build time
  always_comb begin
    cfg_src   = signal_config_mode ? static_cfg_i : shadow_q;
    apply_src = signal_config_mode ? static_apply_i : bus_apply_q;
  end

  // staging record written over the register port
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      shadow_q <= `CFG_RESET;
    end else if (reg_wr_i && !signal_config_mode) begin
      case (reg_addr_i)
        `OFS_CTRL: begin
          shadow_q.core_en <= reg_wdata_i[`CTRL_CORE];
          shadow_q.priority_handling_en <= reg_wdata_i[`CTRL_PRIO];
          shadow_q.phase_gen_en <= reg_wdata_i[`CTRL_PHASE];
          shadow_q.shaper_global_en <= reg_wdata_i[`CTRL_SHAPER];
          shadow_q.size_filter_en <= reg_wdata_i[`CTRL_SIZE];
          shadow_q.cyclic_forward_en <= reg_wdata_i[`CTRL_CYCLIC];
          shadow_q.lowest_queue_preempt_en <= reg_wdata_i[`CTRL_PREEMPT];
          shadow_q.early_forward_mode <= reg_wdata_i[`CTRL_EARLY];
          shadow_q.accept_all_frames <= reg_wdata_i[`CTRL_ALL];
        end
        `OFS_QEN: begin
          shadow_q.queue_enable_mask <= reg_wdata_i[7:0];
          shadow_q.shaper_queue_en <= reg_wdata_i[15:8];
          shadow_q.size_filter_queue_en <= reg_wdata_i[23:16];
        end
        `OFS_CYCLE: shadow_q.cycle_length_ns <= reg_wdata_i;
        `OFS_VLAN: shadow_q.queue_vlan_priority_map <= reg_wdata_i[23:0];
        `OFS_MAC_LO: shadow_q.node_mac_address[31:0] <= reg_wdata_i;
        `OFS_MAC_HI: shadow_q.node_mac_address[47:32] <= reg_wdata_i[15:0];
        default: begin
          case (blk)
            `BLK_OPEN: shadow_q.phase_open_ns[qi] <= reg_wdata_i;
            `BLK_CLOSE: shadow_q.phase_close_ns[qi] <= reg_wdata_i;
            `BLK_INC: shadow_q.shaper_increment[qi] <= reg_wdata_i[15:0];
            `BLK_DEC: shadow_q.shaper_decrement[qi] <= reg_wdata_i[15:0];
            `BLK_SIZE: shadow_q.queue_size_limit[qi] <= reg_wdata_i[15:0];
            default: ;
          endcase
        end
      endcase
    end
  end

  // a write to the apply register raises the group flags for one cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bus_apply_q <= `CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == `OFS_APPLY) begin
      bus_apply_q <= apply_t'(reg_wdata_i[7:0]);
    end else begin
      bus_apply_q <= `CFG_RESET;
    end
  end

  // active record, each group taken only on its own flag
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      active_q <= `CFG_RESET;
    end else begin
      if (apply_src.prio) begin
        active_q.priority_handling_en <= cfg_src.priority_handling_en;
        active_q.queue_enable_mask <= cfg_src.queue_enable_mask;
      end
      if (apply_src.phase) begin
        active_q.phase_open_ns <= cfg_src.phase_open_ns;
        active_q.phase_close_ns <= cfg_src.phase_close_ns;
        active_q.phase_gen_en <= cfg_src.phase_gen_en;
        active_q.cycle_length_ns <= cfg_src.cycle_length_ns;
      end
      if (apply_src.credit) begin
        active_q.shaper_increment <= cfg_src.shaper_increment;
        active_q.shaper_decrement <= cfg_src.shaper_decrement;
        active_q.shaper_global_en <= cfg_src.shaper_global_en;
        active_q.shaper_queue_en <= cfg_src.shaper_queue_en;
      end
      if (apply_src.apply_size_filter_group) begin
        active_q.queue_size_limit <= cfg_src.queue_size_limit;
        active_q.size_filter_en <= cfg_src.size_filter_en;
        active_q.size_filter_queue_en <= cfg_src.size_filter_queue_en;
      end
      if (apply_src.cyclic) begin
        active_q.cyclic_forward_en <= cfg_src.cyclic_forward_en;
      end
      if (apply_src.preempt) begin
        active_q.lowest_queue_preempt_en <= cfg_src.lowest_queue_preempt_en;
      end
      if (apply_src.vlan) begin
        active_q.queue_vlan_priority_map <= cfg_src.queue_vlan_priority_map;
      end
      if (apply_src.enable) begin
        active_q.core_en <= cfg_src.core_en;
        active_q.early_forward_mode <= cfg_src.early_forward_mode;
        active_q.node_mac_address <= cfg_src.node_mac_address;
        active_q.accept_all_frames <= cfg_src.accept_all_frames;
      end
    end
  end

  // read mux shows the applied record and live state
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr_i)
      `OFS_CTRL: begin
        rd_mux[`CTRL_CORE] = active_q.core_en;
        rd_mux[`CTRL_PRIO] = active_q.priority_handling_en;
        rd_mux[`CTRL_PHASE] = active_q.phase_gen_en;
        rd_mux[`CTRL_SHAPER] = active_q.shaper_global_en;
        rd_mux[`CTRL_SIZE] = active_q.size_filter_en;
        rd_mux[`CTRL_CYCLIC] = active_q.cyclic_forward_en;
        rd_mux[`CTRL_PREEMPT] = active_q.lowest_queue_preempt_en;
        rd_mux[`CTRL_EARLY] = active_q.early_forward_mode;
        rd_mux[`CTRL_ALL] = active_q.accept_all_frames;
      end
      `OFS_QEN: rd_mux[23:0] = {active_q.size_filter_queue_en,
                                active_q.shaper_queue_en,
                                active_q.queue_enable_mask};
      `OFS_CYCLE: rd_mux = active_q.cycle_length_ns;
      `OFS_VLAN: rd_mux[23:0] = active_q.queue_vlan_priority_map;
      `OFS_MAC_LO: rd_mux = active_q.node_mac_address[31:0];
      `OFS_MAC_HI: rd_mux[15:0] = active_q.node_mac_address[47:32];
      `OFS_STATUS: rd_mux[15:0] = {status_q.phase, 3'h0, phase_valid_q,
                                   status_q.cycle_start,
                                   status_q.side_b_supervision_lost,
                                   status_q.side_a_supervision_lost,
                                   status_q.core_enabled};
      `OFS_ELAPSED: rd_mux = elapsed_q;
      default: begin
        case (blk)
          `BLK_OPEN: rd_mux = active_q.phase_open_ns[qi];
          `BLK_CLOSE: rd_mux = active_q.phase_close_ns[qi];
          `BLK_INC: rd_mux[15:0] = active_q.shaper_increment[qi];
          `BLK_DEC: rd_mux[15:0] = active_q.shaper_decrement[qi];
          `BLK_SIZE: rd_mux[15:0] = active_q.queue_size_limit[qi];
          default: rd_mux = 32'h0000_0000;
        endcase
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !reg_rd_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  // cycle timer advances one clock period per edge
  assign phase_run = active_q.core_en && active_q.phase_gen_en;
  assign next_el = {1'b0, elapsed_q} + {1'b0, PERIOD_NS};
  assign wrap = next_el >= {1'b0, active_q.cycle_length_ns};

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !phase_run) begin
      elapsed_q <= 32'h0000_0000;
      run_q <= 1'b0;
      cycle_start_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
      if (!run_q || wrap) begin
        elapsed_q <= 32'h0000_0000;
        cycle_start_q <= 1'b1;
      end else begin
        elapsed_q <= next_el[31:0];
        cycle_start_q <= 1'b0;
      end
    end
  end

  // phase from open and close offsets, gated by the queue enable mask
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      phase_q <= '0;
      phase_valid_q <= 1'b0;
    end else begin
      phase_valid_q <= phase_run && run_q;
      for (int i = 0; i < NQ; i++) begin
        phase_q[i] <= phase_run && run_q &&
          active_q.queue_enable_mask[i] &&
          elapsed_q >= active_q.phase_open_ns[i] &&
          elapsed_q < active_q.phase_close_ns[i];
      end
    end
  end

  // supervision watchdog per network side
  assign sup_evt = {side_b_sup_frame_i, side_a_sup_frame_i};

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !active_q.core_en) begin
      sup_cnt_q <= '0;
      lost_q <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (sup_evt[s]) begin
          sup_cnt_q[s] <= 32'h0000_0000;
          lost_q[s] <= 1'b0;
        end else if (sup_cnt_q[s] >= SUP_LIMIT) begin
          lost_q[s] <= 1'b1;
        end else begin
          sup_cnt_q[s] <= sup_cnt_q[s] + 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      core_enabled_q <= 1'b0;
      lost_flag_q <= 2'h0;
    end else begin
      core_enabled_q <= active_q.core_en;
      lost_flag_q <= lost_q;
    end
  end

  // credit based shaper per queue
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NQ; i++) begin
      if (!rst_n_i || !(active_q.core_en && active_q.shaper_global_en &&
          active_q.shaper_queue_en[i])) begin
        credit_q[i] <= 18'sh00000;
      end else if (queue_sending_i[i]) begin
        credit_q[i] <= credit_q[i] -
          $signed({2'b00, active_q.shaper_decrement[i]});
      end else if (queue_pending_i[i]) begin
        if (credit_q[i] < 18'sh10000) begin
          credit_q[i] <= credit_q[i] +
            $signed({2'b00, active_q.shaper_increment[i]});
        end
      end else if (credit_q[i] > 18'sh00000) begin
        credit_q[i] <= 18'sh00000;
      end
    end
  end

  // gating outputs
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      queue_active_q <= 8'h00;
      shaper_allow_q <= 8'hFF;
      preempt_allow_q <= 8'h00;
      cyclic_q <= 1'b0;
      early_q <= 1'b0;
    end else begin
      queue_active_q <= active_q.queue_enable_mask &
        {NQ{active_q.core_en && active_q.priority_handling_en}};
      for (int i = 0; i < NQ; i++) begin
        shaper_allow_q[i] <= !(active_q.core_en &&
          active_q.shaper_global_en && active_q.shaper_queue_en[i]) ||
          !credit_q[i][17];
      end
      preempt_allow_q <= {active_q.core_en &&
        active_q.lowest_queue_preempt_en, 7'h00};
      cyclic_q <= active_q.core_en && active_q.cyclic_forward_en;
      early_q <= active_q.core_en && active_q.early_forward_mode;
    end
  end

  // queue selection, lowest matching index wins
  always_comb begin
    sel_queue = 3'(NQ - 1);
    if (active_q.priority_handling_en) begin
      for (int i = NQ - 1; i >= 0; i--) begin
        if (active_q.queue_vlan_priority_map[i] == frame_i.pcp) begin
          sel_queue = 3'(i);
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      verdict_q <= '0;
    end else begin
      verdict_q.valid <= frame_i.valid;
      verdict_q.queue <= sel_queue;
      verdict_q.size_drop <= active_q.core_en && active_q.size_filter_en &&
        active_q.size_filter_queue_en[sel_queue] &&
        frame_i.length > active_q.queue_size_limit[sel_queue];
      verdict_q.accept <= frame_i.valid && active_q.core_en &&
        (active_q.accept_all_frames ||
         frame_i.dst_mac == active_q.node_mac_address ||
         frame_i.dst_mac[40]) &&
        !(active_q.size_filter_en &&
          active_q.size_filter_queue_en[sel_queue] &&
          frame_i.length > active_q.queue_size_limit[sel_queue]);
    end
  end

  assign reg_rdata_o      = rdata_q;
  assign verdict_o        = verdict_q;
  assign active_cfg_o     = active_q;
  assign queue_active_o   = queue_active_q;
  assign shaper_allow_o   = shaper_allow_q;
  assign preempt_allow_o  = preempt_allow_q;
  assign cyclic_forward_o = cyclic_q;
  assign early_forward_o  = early_q;
  assign status_o         = status_q;
  assign phase_valid_o    = phase_valid_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_phase_window: assert property (
    (phase_run && run_q && active_q.queue_enable_mask[0] &&
     elapsed_q >= active_q.phase_open_ns[0] &&
     elapsed_q < active_q.phase_close_ns[0]) |=> status_q.phase[0]
  ) else $error("queue 0 phase not open inside its window");

  chk_phase_closed: assert property (
    (elapsed_q >= active_q.phase_close_ns[0]) |=> !status_q.phase[0]
  ) else $error("queue 0 phase open after its close offset");

  chk_cycle_restart: assert property (
    (phase_run && run_q && wrap) |=>
      status_q.cycle_start && elapsed_q == 32'h0000_0000
  ) else $error("cycle did not restart at its length");

  chk_idle_timer: assert property (
    !phase_run |=> elapsed_q == 32'h0000_0000 && !status_q.cycle_start
      ##1 status_q.phase == '0 && !phase_valid_q
  ) else $error("timer or phases running while disabled");

  chk_preempt_lowest: assert property (
    preempt_allow_q[NQ-2:0] == 7'h00
  ) else $error("preemption allowed on a higher queue");

  chk_group_hold: assert property (
    !apply_src.phase |=> $stable(active_q.cycle_length_ns)
  ) else $error("phase group changed without its apply flag");

  chk_group_take: assert property (
    apply_src.enable |=> active_q.core_en == $past(cfg_src.core_en)
  ) else $error("enable group not taken on its apply flag");

  chk_shaper_off: assert property (
    !active_q.shaper_global_en |=> shaper_allow_q == 8'hFF
  ) else $error("shaper blocks traffic while globally off");

  chk_size_drop: assert property (
    (frame_i.valid && active_q.core_en && active_q.size_filter_en &&
     active_q.size_filter_queue_en[sel_queue] &&
     frame_i.length > active_q.queue_size_limit[sel_queue]) |=>
      verdict_q.size_drop && !verdict_q.accept
  ) else $error("oversized frame not dropped");

  chk_core_status: assert property (
    ##1 status_q.core_enabled == $past(active_q.core_en)
  ) else $error("core enabled status does not follow enable");

  chk_sup_clear: assert property (
    (side_a_sup_frame_i && active_q.core_en) |=> ##1
      !status_q.side_a_supervision_lost
  ) else $error("side a loss flag kept after a supervision frame");

  cov_cycle_start: cover property (status_q.cycle_start ##1 phase_valid_q);
  cov_phase_open: cover property ($rose(status_q.phase[0]));
  cov_frame_accept: cover property (verdict_q.valid && verdict_q.accept);
  cov_side_lost: cover property ($rose(status_q.side_a_supervision_lost));
endmodule
`default_nettype wire

//--- core/tsn_sched_consts.svh
// constants for the configuration front end and phase scheduler
`ifndef TSN_SCHED_CONSTS_SVH
`define TSN_SCHED_CONSTS_SVH
`define MAX_QUEUES      8
`define CLK_FREQ_MHZ    40
`define CLK_PERIOD_NS   (1000 / `CLK_FREQ_MHZ)
`define SUP_TIMEOUT_MS  1
`define SUP_TIMEOUT_CYC (`SUP_TIMEOUT_MS * 1000 * 1000 / `CLK_PERIOD_NS)
`define CFG_RESET       '0
`define OFS_CTRL        10'h000
`define OFS_QEN         10'h004
`define OFS_CYCLE       10'h008
`define OFS_VLAN        10'h00C
`define OFS_MAC_LO      10'h010
`define OFS_MAC_HI      10'h014
`define OFS_APPLY       10'h018
`define OFS_STATUS      10'h01C
`define OFS_ELAPSED     10'h020
`define BLK_OPEN        5'h02
`define BLK_CLOSE       5'h03
`define BLK_INC         5'h04
`define BLK_DEC         5'h05
`define BLK_SIZE        5'h06
`define CTRL_CORE       0
`define CTRL_PRIO       1
`define CTRL_PHASE      2
`define CTRL_SHAPER     3
`define CTRL_SIZE       4
`define CTRL_CYCLIC     5
`define CTRL_PREEMPT    6
`define CTRL_EARLY      7
`define CTRL_ALL        8
`endif

//--- core/tsn_sched_pkg.sv
// types shared by the configuration front end and its users
package tsn_sched_pkg;
  `include "tsn_sched_consts.svh"
  typedef struct packed {
    logic [`MAX_QUEUES-1:0][2:0]  queue_vlan_priority_map;
    logic                         priority_handling_en;
    logic [`MAX_QUEUES-1:0]       queue_enable_mask;
    logic [`MAX_QUEUES-1:0][31:0] phase_open_ns;
    logic [`MAX_QUEUES-1:0][31:0] phase_close_ns;
    logic                         phase_gen_en;
    logic [31:0]                  cycle_length_ns;
    logic [`MAX_QUEUES-1:0][15:0] shaper_increment;
    logic [`MAX_QUEUES-1:0][15:0] shaper_decrement;
    logic                         shaper_global_en;
    logic [`MAX_QUEUES-1:0]       shaper_queue_en;
    logic [`MAX_QUEUES-1:0][15:0] queue_size_limit;
    logic                         size_filter_en;
    logic [`MAX_QUEUES-1:0]       size_filter_queue_en;
    logic                         cyclic_forward_en;
    logic                         lowest_queue_preempt_en;
    logic                         early_forward_mode;
    logic [47:0]                  node_mac_address;
    logic                         accept_all_frames;
    logic                         core_en;
  } cfg_t;
  typedef struct packed {
    logic enable;
    logic vlan;
    logic preempt;
    logic cyclic;
    logic apply_size_filter_group;
    logic credit;
    logic phase;
    logic prio;
  } apply_t;
  typedef struct packed {
    logic [`MAX_QUEUES-1:0] phase;
    logic                   cycle_start;
    logic                   side_b_supervision_lost;
    logic                   side_a_supervision_lost;
    logic                   core_enabled;
  } status_t;
  typedef struct packed {
    logic        valid;
    logic [47:0] dst_mac;
    logic [2:0]  pcp;
    logic [15:0] length;
  } frame_desc_t;
  typedef struct packed {
    logic       valid;
    logic       accept;
    logic       size_drop;
    logic [2:0] queue;
  } frame_verdict_t;
endpackage

//--- tb/tsn_cfg_master.sv
// register bus master standing in for the configuring processor
`timescale 1ns/1ps
`default_nettype none
module tsn_cfg_master (
  // bus side
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  output logic      [9:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  task automatic put(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic get(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

//--- tb/tsn_config_phase_scheduler_tb_top.sv
// bench for the configuration front end and phase scheduler
`timescale 1ns/1ps
`default_nettype none
module tsn_config_phase_scheduler_tb_top;
  import tsn_sched_pkg::*;
  logic           core_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           sup_a = 1'b0;
  logic [9:0]     addr;
  logic [31:0]    wdata, rdata, d;
  logic           wr, rd, pv;
  status_t        st;
  logic [7:0]     qact, shp, pre;
  frame_desc_t    frm = '0;
  frame_verdict_t vd;
  cfg_t           acfg;
  logic [7:0]     pend = 8'h00;
  logic [7:0]     send = 8'h00;
  logic           cyc, ef;
  int             n_errors = 0;
  int             checks_done = 0;
  int             n, ph;
  always #12.5 core_clk = ~core_clk;
  tsn_cfg_master i_tsn_cfg_master (.clk_i(core_clk), .rdata_i(rdata),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  tsn_config_phase_scheduler #(.SUP_TIMEOUT_CYC(20))
    i_tsn_config_phase_scheduler (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .static_cfg_i('0), .static_apply_i('0), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .frame_i(frm), .verdict_o(vd), .queue_pending_i(pend),
    .queue_sending_i(send), .side_a_sup_frame_i(sup_a),
    .side_b_sup_frame_i(1'b0), .active_cfg_o(acfg), .queue_active_o(qact),
    .shaper_allow_o(shp), .preempt_allow_o(pre), .cyclic_forward_o(cyc),
    .early_forward_o(ef), .status_o(st), .phase_valid_o(pv));
  // one frame descriptor for one cycle, verdict read just after it is cleared
  task automatic send_frame(input logic [47:0] m, input logic [2:0] p,
                            input logic [15:0] l);
    @(posedge core_clk);
    frm <= {1'b1, m, p, l};
    @(posedge core_clk);
    frm <= '0;
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  initial begin
    #(25 * 4000);
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    sup_a <= 1'b1;
    wait_cyc(1);
    chk(32'(st), 32'h0);
    chk(32'(shp), 32'hFF);
    i_tsn_cfg_master.put(10'h000, 32'h047);
    i_tsn_cfg_master.put(10'h004, 32'h0F);
    i_tsn_cfg_master.put(10'h008, 32'd250);
    i_tsn_cfg_master.put(10'h040, 32'd0);
    i_tsn_cfg_master.put(10'h060, 32'd100);
    i_tsn_cfg_master.get(10'h000, d);
    chk(d, 32'h0);
    i_tsn_cfg_master.put(10'h018, 32'h80);
    i_tsn_cfg_master.get(10'h000, d);
    chk(d, 32'h1);
    chk(32'(st.core_enabled), 32'h1);
    chk(32'(qact), 32'h0);
    i_tsn_cfg_master.put(10'h018, 32'h01);
    wait_cyc(2);
    chk(32'(qact), 32'h0F);
    chk(32'(pre), 32'h0);
    i_tsn_cfg_master.put(10'h018, 32'h20);
    wait_cyc(2);
    chk(32'(pre), 32'h80);
    chk(32'(pv), 32'h0);
    i_tsn_cfg_master.put(10'h018, 32'h02);
    n = 0;
    while (st.cycle_start !== 1'b1 && n < 40) begin
      wait_cyc(1);
      n++;
    end
    n = 0;
    ph = 0;
    do begin
      wait_cyc(1);
      n++;
      ph += int'(st.phase[0] === 1'b1);
    end while (st.cycle_start !== 1'b1 && n < 50);
    chk(32'(n), 32'd10);
    chk(32'(ph), 32'd4);
    chk(32'(pv), 32'h1);
    wait_cyc(30);
    chk(32'(st.side_a_supervision_lost), 32'h0);
    chk(32'(st.side_b_supervision_lost), 32'h1);
    i_tsn_cfg_master.get(10'h3FC, d);
    chk(d, 32'h0);
    i_tsn_cfg_master.put(10'h000, 32'h0FF);
    i_tsn_cfg_master.put(10'h004, 32'h0001_010F);
    i_tsn_cfg_master.put(10'h00C, 32'h5);
    i_tsn_cfg_master.put(10'h0C0, 32'd100);
    i_tsn_cfg_master.put(10'h080, 32'h10);
    i_tsn_cfg_master.put(10'h0A0, 32'h30);
    i_tsn_cfg_master.put(10'h010, 32'h1234_5678);
    i_tsn_cfg_master.put(10'h014, 32'h0A00);
    i_tsn_cfg_master.put(10'h018, 32'hFF);
    wait_cyc(2);
    chk(32'({cyc, ef}), 32'h3);
    chk(32'(acfg.node_mac_address[47:32]), 32'h0A00);
    send_frame(48'h0A00_1234_5678, 3'd5, 16'd64);
    chk(32'(vd), 32'h30);
    send_frame(48'h0A00_1234_5679, 3'd0, 16'd64);
    chk(32'(vd), 32'h21);
    send_frame(48'h0A00_1234_5678, 3'd5, 16'd200);
    chk(32'(vd), 32'h28);
    @(posedge core_clk);
    send <= 8'h01;
    @(posedge core_clk);
    send <= 8'h00;
    wait_cyc(1);
    chk(32'(shp), 32'hFE);
    @(posedge core_clk);
    pend <= 8'h01;
    wait_cyc(3);
    chk(32'(shp), 32'hFE);
    wait_cyc(1);
    chk(32'(shp), 32'hFF);
    @(posedge core_clk);
    pend <= 8'h00;
    i_tsn_cfg_master.put(10'h000, 32'h1FF);
    i_tsn_cfg_master.put(10'h018, 32'h80);
    send_frame(48'h0A00_1234_5679, 3'd0, 16'd64);
    chk(32'(vd), 32'h31);
    finish_test();
  end
endmodule
`default_nettype wire
